// file: inc/ssp_pkg.sv
// package: register map, reset values, ranges and scaling constants of the speed profile block
package ssp_pkg;
    // parameter addresses (16-bit words)
    localparam logic [15:0] ADDR_ACCEL_TIME = 16'h0144;
    localparam logic [15:0] ADDR_DECEL_TIME = 16'h0146;
    localparam logic [15:0] ADDR_SMOOTH_TIME = 16'h0148;
    localparam logic [15:0] ADDR_INERTIA = 16'h014A;
    localparam logic [15:0] ADDR_ZERO_SPEED = 16'h014C;
    localparam logic [15:0] ADDR_TARGET_SPEED = 16'h014E;
    localparam logic [15:0] ADDR_SPEED_SCALE = 16'h0150;
    localparam logic [15:0] ADDR_TORQUE_SCALE = 16'h0152;
    localparam logic [15:0] ADDR_STATUS = 16'h0160;
    // reset values
    localparam logic [15:0] RST_ACCEL_TIME = 16'h00C8;
    localparam logic [15:0] RST_DECEL_TIME = 16'h00C8;
    localparam logic [15:0] RST_SMOOTH_TIME = 16'h0000;
    localparam logic [15:0] RST_INERTIA = 16'h000A;
    localparam logic [15:0] RST_ZERO_SPEED = 16'h0064;
    localparam logic [15:0] RST_TARGET_SPEED = 16'h0BB8;
    localparam logic [15:0] RST_SPEED_SCALE = 16'h0BB8;
    localparam logic [15:0] RST_TORQUE_SCALE = 16'h0064;
    // largest accepted values, plus the smallest accepted ramp time
    localparam logic [15:0] MAX_RAMP_TIME = 16'h4E20;
    localparam logic [15:0] MIN_RAMP_TIME = 16'h0001;
    localparam logic [15:0] MAX_SMOOTH_TIME = 16'h2710;
    localparam logic [15:0] MAX_INERTIA = 16'h07D0;
    localparam logic [15:0] MAX_ZERO_SPEED = 16'h07D0;
    localparam logic [15:0] MAX_TARGET_SPEED = 16'h1388;
    localparam logic [15:0] MAX_SPEED_SCALE = 16'h2710;
    localparam logic [15:0] MAX_TORQUE_SCALE = 16'h03E8;
    // analog voltage in millivolts, full scale 10 V
    localparam logic [15:0] FULL_SCALE_MV = 16'h2710;
    // speed flags compare in 0.1 r/min units
    localparam logic [15:0] TENTH_PER_RPM = 16'h000A;
    // status bit positions
    localparam int ST_ZERO = 0;
    localparam int ST_TARGET = 1;
    localparam int ST_ANALOG = 2;
    localparam int ST_RAMPING = 3;
    // control modes
    typedef enum logic [1:0] {
        SSP_MODE_PULSE = 2'h0,
        SSP_MODE_SPEED = 2'h1,
        SSP_MODE_TORQUE = 2'h2
    } ssp_mode_e;
    // ramp machine states, one-hot
    typedef enum logic [3:0] {
        SSP_IDLE = 4'h1,
        SSP_RAMP = 4'h2,
        SSP_SMOOTH = 4'h4,
        SSP_HOLD = 4'h8
    } ssp_ramp_e;
endpackage

// file: inc/ssp_scale_if.sv
// interface: analog scaling request and results between top and scaler
`timescale 1ns/1ps
interface ssp_scale_if;
    logic signed [15:0] voltMv;
    logic [15:0] speedScale;
    logic [15:0] torqueScale;
    logic signed [15:0] speedOut;
    logic signed [15:0] torqueOut;
    modport owner (output voltMv, speedScale, torqueScale, input speedOut, torqueOut);
    modport scaler (input voltMv, speedScale, torqueScale, output speedOut, torqueOut);
endinterface

// file: hw/ssp_scaler.sv
// module: linear 10 V full-scale conversion of analog inputs to speed and torque values
`timescale 1ns/1ps
module ssp_scaler
    import ssp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic signed [15:0] torqueVoltMv,
    ssp_scale_if.scaler sc
);
    // product fits 32 bits: 10000 mV * 10000 r/min
    logic signed [31:0] speedProd;
    logic signed [31:0] torqueProd;
    assign speedProd = 32'(sc.voltMv) * $signed({16'h0000, sc.speedScale});
    assign torqueProd = 32'(torqueVoltMv) * $signed({16'h0000, sc.torqueScale});
    always_ff @(posedge mclk) begin
        if (rst) begin
            sc.speedOut <= 16'sh0000;
            sc.torqueOut <= 16'sh0000;
        end else begin
            sc.speedOut <= 16'(speedProd / $signed({16'h0000, FULL_SCALE_MV}));
            sc.torqueOut <= 16'(torqueProd / $signed({16'h0000, FULL_SCALE_MV}));
        end
    end
endmodule

// file: hw/ssp_core.sv
// module: speed profile, inertia store, speed flags and analog command scaling
`timescale 1ns/1ps
module ssp_core
    import ssp_pkg::*;
#(
    parameter int CLK_HZ = 25000000,
    parameter int MS_CYCLES = CLK_HZ / 1000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic parWrite,
    input wire logic parRead,
    input wire logic [15:0] parAddr,
    input wire logic [15:0] parWdata,
    output logic [15:0] parRdata,
    output logic parError,
    input wire logic [1:0] ctrlMode,
    input wire logic analogSource,
    input wire logic signed [15:0] speedVoltMv,
    input wire logic signed [15:0] torqueVoltMv,
    input wire logic signed [15:0] motorSpeed,
    input wire logic moveStart,
    input wire logic moveDecel,
    output logic zero_speed_flag,
    output logic target_speed_reached,
    output logic signed [15:0] speedCommand,
    output logic signed [15:0] speedLimit,
    output logic signed [15:0] torqueCommand,
    output logic signed [15:0] torqueLimit,
    output logic [15:0] profileMs,
    output logic rampActive,
    output logic rampDecel
);
    logic [15:0] accel_ramp_time;
    logic [15:0] decel_ramp_time;
    logic [15:0] scurve_smoothing_time;
    logic [15:0] load_inertia_ratio;
    logic [15:0] zero_speed_threshold;
    logic [15:0] target_speed_threshold;
    logic [15:0] analog_speed_full_scale;
    logic [15:0] analog_torque_full_scale;

    // value accepted only inside its documented range; out-of-range writes are refused
    function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    wire hitAccel = parAddr == ADDR_ACCEL_TIME;
    wire hitDecel = parAddr == ADDR_DECEL_TIME;
    wire hitSmooth = parAddr == ADDR_SMOOTH_TIME;
    wire hitInertia = parAddr == ADDR_INERTIA;
    wire hitZero = parAddr == ADDR_ZERO_SPEED;
    wire hitTarget = parAddr == ADDR_TARGET_SPEED;
    wire hitSpeedSc = parAddr == ADDR_SPEED_SCALE;
    wire hitTorqueSc = parAddr == ADDR_TORQUE_SCALE;
    wire hitStatus = parAddr == ADDR_STATUS;
    wire mapped = hitAccel | hitDecel | hitSmooth | hitInertia | hitZero | hitTarget
        | hitSpeedSc | hitTorqueSc | hitStatus;
    wire okAccel = inRange(parWdata, MIN_RAMP_TIME, MAX_RAMP_TIME);
    wire okSmooth = inRange(parWdata, 16'h0000, MAX_SMOOTH_TIME);
    wire okInertia = inRange(parWdata, 16'h0000, MAX_INERTIA);
    wire okZero = inRange(parWdata, 16'h0000, MAX_ZERO_SPEED);
    wire okTarget = inRange(parWdata, 16'h0000, MAX_TARGET_SPEED);
    wire okSpeedSc = inRange(parWdata, 16'h0000, MAX_SPEED_SCALE);
    wire okTorqueSc = inRange(parWdata, 16'h0000, MAX_TORQUE_SCALE);
    wire writeOk = (hitAccel & okAccel) | (hitDecel & okAccel) | (hitSmooth & okSmooth)
        | (hitInertia & okInertia) | (hitZero & okZero) | (hitTarget & okTarget)
        | (hitSpeedSc & okSpeedSc) | (hitTorqueSc & okTorqueSc);

    always_ff @(posedge mclk) begin
        if (rst) begin
            accel_ramp_time <= RST_ACCEL_TIME;
            decel_ramp_time <= RST_DECEL_TIME;
            scurve_smoothing_time <= RST_SMOOTH_TIME;
            load_inertia_ratio <= RST_INERTIA;
            zero_speed_threshold <= RST_ZERO_SPEED;
            target_speed_threshold <= RST_TARGET_SPEED;
            analog_speed_full_scale <= RST_SPEED_SCALE;
            analog_torque_full_scale <= RST_TORQUE_SCALE;
        end else if (parWrite && writeOk) begin
            if (hitAccel) accel_ramp_time <= parWdata;
            if (hitDecel) decel_ramp_time <= parWdata;
            if (hitSmooth) scurve_smoothing_time <= parWdata;
            if (hitInertia) load_inertia_ratio <= parWdata;
            if (hitZero) zero_speed_threshold <= parWdata;
            if (hitTarget) target_speed_threshold <= parWdata;
            if (hitSpeedSc) analog_speed_full_scale <= parWdata;
            if (hitTorqueSc) analog_torque_full_scale <= parWdata;
        end
    end

    // ---------------- speed flags ----------------
    logic [15:0] absSpeed;
    logic [31:0] absTenths;
    logic [31:0] targetTenths;
    assign absSpeed = motorSpeed[15] ? 16'(-motorSpeed) : 16'(motorSpeed);
    assign absTenths = 32'(absSpeed) * 32'(TENTH_PER_RPM);
    assign targetTenths = 32'(target_speed_threshold) * 32'(TENTH_PER_RPM);
    // both flags are pure comparisons, so the release point equals the set point
    wire next_zero = absTenths <= 32'(zero_speed_threshold);
    wire next_target = absTenths >= targetTenths;

    always_ff @(posedge mclk) begin
        if (rst) begin
            zero_speed_flag <= 1'b0;
            target_speed_reached <= 1'b0;
        end else begin
            zero_speed_flag <= next_zero;
            target_speed_reached <= next_target;
        end
    end

    // ---------------- ramp timing ----------------
    // analog source runs without smoothing or ramp
    wire [15:0] effSmooth = analogSource ? 16'h0000 : scurve_smoothing_time;
    wire [15:0] rampTime = moveDecel ? decel_ramp_time : accel_ramp_time;
    wire [16:0] totalMs = 17'(rampTime) + 17'(effSmooth);

    ssp_ramp_e state;
    ssp_ramp_e next_state;
    logic [31:0] msDiv;
    logic [15:0] msLeft;
    logic [15:0] smoothLeft;
    wire msTick = msDiv == 32'(MS_CYCLES - 1);

    always_comb begin
        case (state)
            SSP_IDLE: next_state = (moveStart && !analogSource) ? SSP_RAMP : SSP_IDLE;
            SSP_RAMP: next_state = (msTick && msLeft <= 16'h0001)
                ? ((smoothLeft == 16'h0000) ? SSP_HOLD : SSP_SMOOTH) : SSP_RAMP;
            SSP_SMOOTH: next_state = (msTick && smoothLeft <= 16'h0001) ? SSP_HOLD : SSP_SMOOTH;
            SSP_HOLD: next_state = moveStart ? SSP_HOLD : SSP_IDLE;
            default: next_state = SSP_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= SSP_IDLE;
            msDiv <= 32'h0000_0000;
            msLeft <= 16'h0000;
            smoothLeft <= 16'h0000;
            rampDecel <= 1'b0;
            profileMs <= 16'h0000;
        end else begin
            state <= next_state;
            msDiv <= (state == SSP_IDLE || msTick) ? 32'h0000_0000 : msDiv + 32'h0000_0001;
            if (state == SSP_IDLE && next_state == SSP_RAMP) begin
                msLeft <= rampTime;
                smoothLeft <= effSmooth;
                rampDecel <= moveDecel;
                profileMs <= totalMs[16] ? 16'hFFFF : totalMs[15:0];
            end else if (msTick && state == SSP_RAMP) begin
                msLeft <= msLeft - 16'h0001;
            end else if (msTick && state == SSP_SMOOTH) begin
                smoothLeft <= smoothLeft - 16'h0001;
            end
        end
    end
    assign rampActive = (state == SSP_RAMP) || (state == SSP_SMOOTH);

    // ---------------- analog scaling ----------------
    ssp_scale_if sc ();
    assign sc.voltMv = speedVoltMv;
    assign sc.speedScale = analog_speed_full_scale;
    assign sc.torqueScale = analog_torque_full_scale;
    ssp_scaler u_scaler (
        .mclk(mclk),
        .rst(rst),
        .torqueVoltMv(torqueVoltMv),
        .sc(sc)
    );

    wire modeSpeed = ctrlMode == SSP_MODE_SPEED;
    wire modeTorque = ctrlMode == SSP_MODE_TORQUE;
    wire modePulse = ctrlMode == SSP_MODE_PULSE;
    always_ff @(posedge mclk) begin
        if (rst) begin
            speedCommand <= 16'sh0000;
            speedLimit <= 16'sh0000;
            torqueCommand <= 16'sh0000;
            torqueLimit <= 16'sh0000;
        end else begin
            speedCommand <= modeSpeed ? sc.speedOut : 16'sh0000;
            speedLimit <= modeTorque ? sc.speedOut : 16'sh0000;
            torqueCommand <= modeTorque ? sc.torqueOut : 16'sh0000;
            torqueLimit <= (modePulse || modeSpeed) ? sc.torqueOut : 16'sh0000;
        end
    end

    // ---------------- read side ----------------
    wire [15:0] statusWord = {12'h000, rampActive, analogSource, target_speed_reached, zero_speed_flag};
    wire [15:0] readMux = hitAccel ? accel_ramp_time
        : hitDecel ? decel_ramp_time
        : hitSmooth ? scurve_smoothing_time
        : hitInertia ? load_inertia_ratio
        : hitZero ? zero_speed_threshold
        : hitTarget ? target_speed_threshold
        : hitSpeedSc ? analog_speed_full_scale
        : hitTorqueSc ? analog_torque_full_scale
        : hitStatus ? statusWord : 16'h0000;
    always_ff @(posedge mclk) begin
        if (rst) begin
            parRdata <= 16'h0000;
            parError <= 1'b0;
        end else begin
            parRdata <= parRead ? readMux : 16'h0000;
            parError <= (parWrite && !writeOk) || (parRead && !mapped);
        end
    end
endmodule

// file: test/ssp_core_monitor.sv
// checker: port-level properties of the speed profile block
`timescale 1ns/1ps
module ssp_core_monitor
    import ssp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic parWrite,
    input wire logic parRead,
    input wire logic [15:0] parAddr,
    input wire logic [15:0] parWdata,
    input wire logic parError,
    input wire logic analogSource,
    input wire logic signed [15:0] motorSpeed,
    input wire logic zero_speed_flag,
    input wire logic target_speed_reached,
    input wire logic rampActive
);
    logic [15:0] zThr;
    logic [15:0] tThr;
    int absSpd;
    assign absSpd = motorSpeed < 0 ? -int'(motorSpeed) : int'(motorSpeed);
    // refused writes must not move the shadow
    always_ff @(posedge mclk) begin
        if (rst) begin
            zThr <= RST_ZERO_SPEED;
            tThr <= RST_TARGET_SPEED;
        end else if (parWrite && parAddr == ADDR_ZERO_SPEED && parWdata <= MAX_ZERO_SPEED) begin
            zThr <= parWdata;
        end else if (parWrite && parAddr == ADDR_TARGET_SPEED && parWdata <= MAX_TARGET_SPEED) begin
            tThr <= parWdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence slowSpd;
        absSpd * 10 <= int'(zThr);
    endsequence
    sequence fastSpd;
        absSpd >= int'(tThr);
    endsequence
    sequence analogIdle;
        analogSource && !rampActive;
    endsequence
    zero_set_a: assert property (slowSpd |=> zero_speed_flag) else $error("zero flag low");
    zero_clear_a: assert property (absSpd * 10 > int'(zThr) |=> !zero_speed_flag) else $error("zero flag high");
    target_set_a: assert property (fastSpd |=> target_speed_reached) else $error("target flag low");
    target_drop_a: assert property (absSpd < int'(tThr) |=> !target_speed_reached) else $error("target high");
    reverse_speed_a: assert property (motorSpeed < 0 && absSpd >= int'(tThr) |=> target_speed_reached)
        else $error("reverse speed ignored");
    inertia_range_a: assert property (parWrite && parAddr == ADDR_INERTIA && parWdata > MAX_INERTIA |=> parError)
        else $error("inertia over range taken");
    smooth_range_a: assert property (parWrite && parAddr == ADDR_SMOOTH_TIME && parWdata > MAX_SMOOTH_TIME |=> parError)
        else $error("smoothing over range taken");
    analog_ramp_a: assert property (analogIdle |=> !rampActive) else $error("ramp under analog source");
endmodule
bind ssp_core ssp_core_monitor u_mon (.mclk(mclk), .rst(rst), .parWrite(parWrite), .parRead(parRead),
    .parAddr(parAddr), .parWdata(parWdata), .parError(parError), .analogSource(analogSource),
    .motorSpeed(motorSpeed), .zero_speed_flag(zero_speed_flag), .target_speed_reached(target_speed_reached),
    .rampActive(rampActive));

// file: test/ssp_host_model.sv
// partner: host writing and reading drive parameters one word at a time
`timescale 1ns/1ps
module ssp_host_model (
    input wire logic mclk,
    output logic parWrite,
    output logic parRead,
    output logic [15:0] parAddr,
    output logic [15:0] parWdata,
    input wire logic [15:0] parRdata,
    input wire logic parError
);
    initial begin
        parWrite = 1'b0;
        parRead = 1'b0;
        parAddr = 16'h0000;
        parWdata = 16'h0000;
    end
    // bus is scrambled between words so stale values cannot pass
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
        output logic e);
        @(negedge mclk);
        parWrite = w;
        parRead = !w;
        parAddr = a;
        parWdata = d;
        @(negedge mclk);
        q = parRdata;
        e = parError;
        parWrite = 1'b0;
        parRead = 1'b0;
        parAddr = ~a;
        parWdata = ~d;
    endtask
endmodule

// file: test/tb_ssp_core.sv
// testbench: registers, speed flags, analog scaling and ramp timing
`timescale 1ns/1ps
module tb_ssp_core
    import ssp_pkg::*;
;
    localparam int MS = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] ctrlMode = 2'h0;
    logic analogSource = 1'b0, moveStart = 1'b0, moveDecel = 1'b0;
    logic signed [15:0] speedVoltMv = '0, torqueVoltMv = '0, motorSpeed = '0;
    logic signed [15:0] speedCommand, speedLimit, torqueCommand, torqueLimit;
    logic parWrite, parRead, parError, zero_speed_flag, target_speed_reached, rampActive, rampDecel, e;
    logic [15:0] parAddr, parWdata, parRdata, profileMs, q;
    int n_errors = 0, n_checks = 0, seed = 26, cnt, zT, tT, sS, tS, v;
    logic [15:0] regA [8] = '{ADDR_ACCEL_TIME, ADDR_DECEL_TIME, ADDR_SMOOTH_TIME, ADDR_INERTIA,
        ADDR_ZERO_SPEED, ADDR_TARGET_SPEED, ADDR_SPEED_SCALE, ADDR_TORQUE_SCALE};
    logic [15:0] regR [8] = '{RST_ACCEL_TIME, RST_DECEL_TIME, RST_SMOOTH_TIME, RST_INERTIA,
        RST_ZERO_SPEED, RST_TARGET_SPEED, RST_SPEED_SCALE, RST_TORQUE_SCALE};
    logic [15:0] regM [8] = '{MAX_RAMP_TIME, MAX_RAMP_TIME, MAX_SMOOTH_TIME, MAX_INERTIA,
        MAX_ZERO_SPEED, MAX_TARGET_SPEED, MAX_SPEED_SCALE, MAX_TORQUE_SCALE};

    ssp_core #(.MS_CYCLES(MS)) u_dut (
        .mclk(mclk),
        .rst(rst),
        .parWrite(parWrite),
        .parRead(parRead),
        .parAddr(parAddr),
        .parWdata(parWdata),
        .parRdata(parRdata),
        .parError(parError),
        .ctrlMode(ctrlMode),
        .analogSource(analogSource),
        .speedVoltMv(speedVoltMv),
        .torqueVoltMv(torqueVoltMv),
        .motorSpeed(motorSpeed),
        .moveStart(moveStart),
        .moveDecel(moveDecel),
        .zero_speed_flag(zero_speed_flag),
        .target_speed_reached(target_speed_reached),
        .speedCommand(speedCommand),
        .speedLimit(speedLimit),
        .torqueCommand(torqueCommand),
        .torqueLimit(torqueLimit),
        .profileMs(profileMs),
        .rampActive(rampActive),
        .rampDecel(rampDecel)
    );
    ssp_host_model u_host (
        .mclk(mclk),
        .parWrite(parWrite),
        .parRead(parRead),
        .parAddr(parAddr),
        .parWdata(parWdata),
        .parRdata(parRdata),
        .parError(parError)
    );

    always #20 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic x);
        u_host.xfer(1'b1, a, d, q, e);
        chk({15'h0, e}, {15'h0, x}, "write error");
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] x);
        u_host.xfer(1'b0, a, 16'h0000, q, e);
        chk(q, x, "read data");
    endtask
    function automatic logic [15:0] sc(input int volt, input int scale);
        return 16'(volt * scale / 10000);
    endfunction
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // whole run is well under a millisecond of model time
    initial begin
        #2000000;
        n_errors++;
        results();
    end

    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(regA[i], regR[i]);
            wr(regA[i], regM[i] + 16'h0001, 1'b1);
            rd(regA[i], regR[i]);
            wr(regA[i], regM[i], 1'b0);
            rd(regA[i], regM[i]);
            wr(regA[i], regR[i], 1'b0);
        end
        wr(ADDR_STATUS, 16'h0001, 1'b1);
        rd(16'h0100, 16'h0000);
        chk({15'h0, e}, 16'h0001, "unmapped read");
        $display("test registers done");
        for (int i = 0; i < 60; i++) begin
            if (i % 20 == 0) begin
                zT = {$random(seed)} % 2001;
                zT = zT - zT % 10;
                tT = {$random(seed)} % 5001;
                wr(ADDR_ZERO_SPEED, 16'(zT), 1'b0);
                wr(ADDR_TARGET_SPEED, 16'(tT), 1'b0);
            end
            case (i % 6)
                0: v = tT;
                1: v = -tT;
                2: v = tT - 1;
                3: v = zT / 10;
                4: v = -(zT / 10 + 1);
                default: v = $random(seed) % 6000;
            endcase
            motorSpeed = 16'(v);
            @(negedge mclk);
            cnt = v < 0 ? -v : v;
            chk({15'h0, zero_speed_flag}, {15'h0, 1'(cnt * 10 <= zT)}, "zero flag");
            chk({15'h0, target_speed_reached}, {15'h0, 1'(cnt >= tT)}, "target flag");
        end
        $display("test flags done");
        analogSource = 1'b1;
        for (int m = 0; m < 3; m++) begin
            ctrlMode = 2'(m);
            sS = {$random(seed)} % 10001;
            tS = {$random(seed)} % 1001;
            wr(ADDR_SPEED_SCALE, 16'(sS), 1'b0);
            wr(ADDR_TORQUE_SCALE, 16'(tS), 1'b0);
            for (int k = 0; k < 6; k++) begin
                v = k == 0 ? 10000 : k == 1 ? -10000 : $random(seed) % 10001;
                speedVoltMv = 16'(v);
                torqueVoltMv = 16'(-v);
                repeat (3) @(negedge mclk);
                chk(speedCommand, m == 1 ? sc(v, sS) : 16'h0000, "speed cmd");
                chk(speedLimit, m == 2 ? sc(v, sS) : 16'h0000, "speed lim");
                chk(torqueCommand, m == 2 ? sc(-v, tS) : 16'h0000, "torque cmd");
                chk(torqueLimit, m != 2 ? sc(-v, tS) : 16'h0000, "torque lim");
            end
        end
        $display("test scaling done");
        moveStart = 1'b1;
        repeat (10) @(negedge mclk);
        chk({15'h0, rampActive}, 16'h0000, "analog ramp");
        rd(ADDR_STATUS, {13'h0, 1'b1, 1'(cnt >= tT), 1'(cnt * 10 <= zT)});
        moveStart = 1'b0;
        analogSource = 1'b0;
        for (int r = 0; r < 4; r++) begin
            zT = 1 + r;
            tT = (r % 2) * 2;
            moveDecel = 1'(r / 2);
            wr(r < 2 ? ADDR_ACCEL_TIME : ADDR_DECEL_TIME, 16'(zT), 1'b0);
            wr(ADDR_SMOOTH_TIME, 16'(tT), 1'b0);
            moveStart = 1'b1;
            cnt = 0;
            for (int w = 0; w < 20 && rampActive !== 1'b1; w++) @(negedge mclk);
            while (rampActive === 1'b1 && cnt < 1000) begin
                cnt++;
                @(negedge mclk);
            end
            chk(16'(cnt), 16'((zT + tT) * MS), "ramp cycles");
            chk(profileMs, 16'(zT + tT), "profile ms");
            chk({15'h0, rampDecel}, {15'h0, moveDecel}, "ramp direction");
            moveStart = 1'b0;
            repeat (3) @(negedge mclk);
        end
        $display("test ramp done");
        results();
    end
endmodule
